// ### hw/csc_pkg.sv
package csc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Master clock period in nanoseconds.
  localparam int unsigned SYS_CLK_PERIOD_NS = 20;
  // Master clock periods for one output-rate period (default 60 Hz).
  localparam int unsigned OUT_PERIOD_CYCLES = 833333;
  // Output-rate periods of filter settling after standby release.
  localparam int unsigned SETTLE_PERIODS = 3;
  // Master clock periods that result_ready_n stays high after an update that finds the previous result unread.
  localparam int unsigned UPDATE_HIGH_CYCLES = 500;
  // Width of the conversion result.
  localparam int unsigned RESULT_W = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [2:0]
  {
    CSC_RUN = 3'b001,
    CSC_STANDBY = 3'b010,
    CSC_SETTLE = 3'b100
  } csc_state_t;

endpackage : csc_pkg

// ### hw/csc_standby_ctrl.sv
module csc_standby_ctrl
  import csc_pkg::*;
#(
  parameter int unsigned OUT_PERIOD = OUT_PERIOD_CYCLES,
  parameter int unsigned HIGH_CYCLES = UPDATE_HIGH_CYCLES
)
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cmd_wr,
  input wire logic i_standby_request_bit,
  input wire logic [RESULT_W-1:0] i_sample,
  input wire logic i_read_done,
  output logic o_mclk_out,
  output logic o_standby,
  output logic o_proc_en,
  output logic [RESULT_W-1:0] o_result,
  output logic o_result_ready_n
);

  // ****************************************************************
  // State and counters
  // ****************************************************************
  csc_state_t state_r;
  csc_state_t state_nxt;
  logic [31:0] period_cnt_r;
  logic [1:0] settle_cnt_r;
  logic [15:0] high_cnt_r;
  logic [RESULT_W-1:0] result_r;
  logic ready_n_r;
  logic mclk_r;

  wire period_tick = (period_cnt_r == OUT_PERIOD - 1);
  wire standby_request_bit_set = i_cmd_wr && i_standby_request_bit;
  wire standby_request_bit_clr = i_cmd_wr && !i_standby_request_bit;
  wire settle_done = (state_r == CSC_SETTLE) && period_tick
                     && (settle_cnt_r == 2'(SETTLE_PERIODS - 1));
  wire run_update = (state_r == CSC_RUN) && period_tick;
  wire load = settle_done || run_update;
  wire pulse_active = (high_cnt_r != 16'h0000);

  // ****************************************************************
  // Standby sequencing
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CSC_RUN:
      begin
        if (standby_request_bit_set)
        begin
          state_nxt = CSC_STANDBY;
        end
      end
      CSC_STANDBY:
      begin
        if (standby_request_bit_clr)
        begin
          state_nxt = CSC_SETTLE;
        end
      end
      CSC_SETTLE:
      begin
        if (standby_request_bit_set)
        begin
          state_nxt = CSC_STANDBY;
        end
        else if (settle_done)
        begin
          state_nxt = CSC_RUN;
        end
      end
      default:
      begin
        state_nxt = CSC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state_r <= CSC_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Output-rate timing
  // ****************************************************************
  // filter frozen
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || (state_r == CSC_STANDBY) || (state_nxt == CSC_SETTLE
        && state_r != CSC_SETTLE) || period_tick)
    begin
      period_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      period_cnt_r <= period_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || state_r != CSC_SETTLE)
    begin
      settle_cnt_r <= 2'h0;
    end
    else if (period_tick)
    begin
      settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end

  // ****************************************************************
  // Result register
  // ****************************************************************
  // hold in standby
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      result_r <= RESULT_RST;
    end
    else if (load)
    begin
      result_r <= i_sample;
    end
  end

  // ****************************************************************
  // Data-ready
  // ****************************************************************
  // high window at update of an unread result
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      high_cnt_r <= 16'h0000;
    end
    else if (load && !ready_n_r)
    begin
      // Loading the full length keeps ready high for exactly HIGH_CYCLES clocks.
      high_cnt_r <= 16'(HIGH_CYCLES);
    end
    else if (pulse_active)
    begin
      high_cnt_r <= high_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ready_n_r <= 1'b1;
    end
    else if (load)
    begin
      ready_n_r <= !ready_n_r;
    end
    else if (pulse_active && high_cnt_r == 16'h0001)
    begin
      ready_n_r <= 1'b0;
    end
    else if (i_read_done && !pulse_active)
    begin
      ready_n_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Master clock output
  // ****************************************************************
  // clock runs always
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      mclk_r <= 1'b0;
    end
    else
    begin
      mclk_r <= !mclk_r;
    end
  end

  assign o_mclk_out = mclk_r;
  assign o_standby = (state_r == CSC_STANDBY);
  assign o_proc_en = (state_r != CSC_STANDBY);
  assign o_result = result_r;
  assign o_result_ready_n = ready_n_r;

endmodule : csc_standby_ctrl

// ### test/csc_props_properties.sv
module csc_props
  import csc_pkg::*;
#(
  parameter int OUT_PERIOD = 20,
  parameter int HIGH_CYCLES = 5
)
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cmd_wr,
  input wire logic i_standby_request_bit,
  input wire logic i_read_done,
  input wire logic o_mclk_out,
  input wire logic o_standby,
  input wire logic o_proc_en,
  input wire logic [RESULT_W-1:0] o_result,
  input wire logic o_result_ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S1 = 3 * OUT_PERIOD;
  localparam int H1 = HIGH_CYCLES - 1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  property p_enter;
    i_cmd_wr && i_standby_request_bit && !o_standby |=> o_standby && !o_proc_en;
  endproperty
  a_enter: assert property (p_enter) else $error("late entry");
  property p_hold;
    o_standby |=> $stable(o_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_proc;
    !o_proc_en && !i_cmd_wr |=> !o_proc_en && $stable(o_result);
  endproperty
  a_proc: assert property (p_proc) else $error("processing on");
  property p_settle;
    i_cmd_wr && !i_standby_request_bit && o_standby |=> !o_standby ##S1 $changed(o_result);
  endproperty
  a_settle: assert property (p_settle) else $error("bad settle");
  property p_read;
    i_read_done && !o_result_ready_n |=> o_result_ready_n;
  endproperty
  a_read: assert property (p_read) else $error("read kept ready");
  property p_load;
    $changed(o_result) && $past(o_result_ready_n) |-> !o_result_ready_n;
  endproperty
  a_load: assert property (p_load) else $error("no ready");
  property p_pulse;
    $changed(o_result) && !$past(o_result_ready_n) |->
      (o_result_ready_n throughout ##H1 1'b1) ##1 !o_result_ready_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  property p_mclk;
    !$past(i_srst) |-> o_mclk_out != $past(o_mclk_out);
  endproperty
  a_mclk: assert property (p_mclk) else $error("clock stopped");
endmodule : csc_props

bind csc_standby_ctrl csc_props #(.OUT_PERIOD(OUT_PERIOD), .HIGH_CYCLES(HIGH_CYCLES)) u_props (.*);

// ### test/csc_host_model.sv
module csc_host_model
(
  input wire logic i_sys_clk,
  output logic o_cmd_wr = 1'b0,
  output logic o_bit = 1'b0,
  output logic o_read_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic write_cmd(input logic b);
    @(posedge i_sys_clk);
    o_cmd_wr <= 1'b1;
    o_bit <= b;
    @(posedge i_sys_clk);
    o_cmd_wr <= 1'b0;
  endtask : write_cmd
  task automatic read_result();
    @(posedge i_sys_clk);
    o_read_done <= 1'b1;
    @(posedge i_sys_clk);
    o_read_done <= 1'b0;
  endtask : read_result
endmodule : csc_host_model

// ### test/csc_standby_ctrl_tb.sv
module csc_standby_ctrl_tb;
  import csc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OP = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [RESULT_W-1:0] smp = 16'h0000;
  logic [RESULT_W-1:0] res;
  logic [RESULT_W-1:0] keep;
  logic mclk_prev;
  logic cw, sb, rd, mclk, standby_request_bit, pen, rdy_n;
  int num_errors = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  always @(posedge clk) smp <= smp + 16'h0001;
  csc_host_model host (.i_sys_clk(clk), .o_cmd_wr(cw), .o_bit(sb), .o_read_done(rd));
  csc_standby_ctrl #(.OUT_PERIOD(OP), .HIGH_CYCLES(5)) dut (.i_sys_clk(clk), .i_srst(srst),
    .i_cmd_wr(cw), .i_standby_request_bit(sb), .i_sample(smp), .i_read_done(rd),
    .o_mclk_out(mclk), .o_standby(standby_request_bit), .o_proc_en(pen), .o_result(res),
    .o_result_ready_n(rdy_n));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_low(input int n);
    int i;
    for (i = 0; i < n && rdy_n !== 1'b0; i++)
      step(1);
    if (i == n)
    begin
      num_errors++;
      $display("mismatch at %0t timeout got %h exp %h", $time, rdy_n, 1'b0);
      final_report();
    end
  endtask : wait_low
  task automatic t_run();
    wait_low(4 * OP);
    chk(rdy_n, 1'b0);
    host.read_result();
    #1;
    chk(rdy_n, 1'b1);
    $display("run test done");
  endtask : t_run
  task automatic t_standby_request_bit_read();
    wait_low(2 * OP);
    host.write_cmd(1'b1);
    #1;
    chk({standby_request_bit, pen, rdy_n}, 3'h4);
    keep = res;
    host.read_result();
    #1;
    chk(rdy_n, 1'b1);
    step(2 * OP);
    chk(res, keep);
    mclk_prev = mclk;
    step(1);
    chk(mclk, !mclk_prev);
    $display("standby read test done");
  endtask : t_standby_request_bit_read
  task automatic t_rel_high();
    host.write_cmd(1'b0);
    step(3 * OP - 1);
    chk({standby_request_bit, rdy_n}, 2'h1);
    keep = smp;
    step(1);
    chk(rdy_n, 1'b0);
    chk(res, keep);
    $display("release high test done");
  endtask : t_rel_high
  task automatic t_rel_low();
    host.write_cmd(1'b1);
    host.write_cmd(1'b0);
    step(3 * OP - 1);
    chk(rdy_n, 1'b0);
    step(1);
    chk(rdy_n, 1'b1);
    step(4);
    chk(rdy_n, 1'b1);
    step(1);
    chk(rdy_n, 1'b0);
    $display("release low test done");
  endtask : t_rel_low
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_run();
    t_standby_request_bit_read();
    t_rel_high();
    t_rel_low();
    final_report();
  end
endmodule : csc_standby_ctrl_tb
